/* File: design/cond_jump_defs.vh */
`ifndef COND_JUMP_DEFS_VH
`define COND_JUMP_DEFS_VH

// Opcodes of the conditional jump group
`define OP_JUMP_ON_CARRY           8'hF6
`define OP_JUMP_ON_USER_FLAG_ZERO  8'hB6
`define OP_JUMP_ON_USER_FLAG_ONE   8'h76
`define OP_JUMP_TEST_ZERO_LOW      8'h26
`define OP_JUMP_TEST_ONE_LOW       8'h46
`define OP_ACC_BIT_LOW_PATTERN     5'h12
`define OP_ACC_BIT_LOW_MSB         4
`define OP_ACC_BIT_IDX_MSB         7
`define OP_ACC_BIT_IDX_LSB         5

// Program counter arithmetic
`define PC_PAGE_MSB                7
`define PC_STEP_ONE                12'h001
`define PC_STEP_TWO                12'h002

// Register byte offsets
`define REG_CTRL                   8'h00
`define REG_FLAGS                  8'h04
`define REG_ACC                    8'h08
`define REG_PC                     8'h0C
`define REG_STATUS                 8'h10
`define REG_TAKEN_COUNT            8'h14

// Field positions
`define CTRL_RUN_BIT               0
`define FLAGS_CARRY_BIT            0
`define FLAGS_USER_ZERO_BIT        1
`define FLAGS_USER_ONE_BIT         2
`define STATUS_BUSY_BIT            0
`define STATUS_TAKEN_BIT           1
`define STATUS_TEST_ZERO_BIT       2
`define STATUS_TEST_ONE_BIT        3
`define STATUS_OPCODE_LSB          8
`define STATUS_OPCODE_MSB          15

// Reset values
`define RST_BYTE                   8'h00
`define RST_PC                     12'h000
`define RST_WORD                   32'h00000000
`define RST_COUNT                  16'h0000
`define RST_TEST_SYNC              3'h7

// Machine cycle length in pclk cycles
`define MC_DIV_DEFAULT             15

`endif

/* File: design/jump_condition_eval.v */
`timescale 1ns/100ps
`include "cond_jump_defs.vh"

module jump_condition_eval (
  // Instruction
  input  wire [7:0] opcode,
  // Condition sources
  input  wire       carry,
  input  wire       user_flag_zero,
  input  wire       user_flag_one,
  input  wire       test_input_zero,
  input  wire       test_input_one,
  input  wire [7:0] acc,
  // Result
  output reg        is_jump,
  output reg        take
);

  function is_acc_bit;
    input [7:0] op;
    begin
      is_acc_bit = (op[`OP_ACC_BIT_LOW_MSB:0] == `OP_ACC_BIT_LOW_PATTERN);
    end
  endfunction

  always @* begin
    is_jump = 1'b1;
    take    = 1'b0;
    case (opcode)
      `OP_JUMP_ON_CARRY:          take = carry;
      `OP_JUMP_ON_USER_FLAG_ZERO: take = user_flag_zero;
      `OP_JUMP_ON_USER_FLAG_ONE:  take = user_flag_one;
      `OP_JUMP_TEST_ZERO_LOW:     take = ~test_input_zero;
      `OP_JUMP_TEST_ONE_LOW:      take = ~test_input_one;
      default: begin
        is_jump = is_acc_bit(opcode);
        if (is_acc_bit(opcode))
          take = acc[opcode[`OP_ACC_BIT_IDX_MSB:`OP_ACC_BIT_IDX_LSB]];
      end
    endcase
  end

endmodule // jump_condition_eval

/* File: design/cond_jump_decode.v */
`timescale 1ns/100ps
`include "cond_jump_defs.vh"

module cond_jump_decode #(
  parameter PC_W   = 12,
  parameter DIV_W  = 8,
  parameter MC_DIV = `MC_DIV_DEFAULT
) (
  // Clock and reset
  input  wire            pclk,
  input  wire            presetn,
  // APB slave
  input  wire [7:0]      paddr,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output wire            pready,
  output wire            pslverr,
  // Program memory
  output reg  [PC_W-1:0] pm_addr,
  output wire            pm_rd,
  input  wire [7:0]      pm_data,
  // Test pins
  input  wire            test_input_zero,
  input  wire            test_input_one
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_OP   = 3'b010;
  localparam [2:0] ST_ARG  = 3'b100;
  localparam [DIV_W-1:0] MC_LAST = MC_DIV - 1;

  // Software state
  reg              run_ff;
  reg              carry_ff;
  reg              user_flag_zero_ff;
  reg              user_flag_one_ff;
  reg  [7:0]       acc_ff;
  // Sequencer state
  reg  [2:0]       state_ff;
  reg  [2:0]       nxt_state;
  reg  [PC_W-1:0]  pc_ff;
  reg  [PC_W-1:0]  nxt_pc;
  reg  [PC_W-1:0]  nxt_addr;
  reg  [7:0]       op_ff;
  reg  [7:0]       nxt_op;
  reg              taken_ff;
  reg              nxt_taken;
  reg  [15:0]      taken_count_ff;
  reg  [DIV_W-1:0] div_ff;
  reg  [31:0]      nxt_rdata;
  wire [PC_W-1:0]  pc_target;
  wire [PC_W-1:0]  pc_fall;
  // Test input conditioning
  reg  [2:0]       t_sync_ff [0:1];
  reg  [1:0]       t_level_ff;
  wire [1:0]       t_pin;
  // Decode results
  wire             is_jump;
  wire             take;
  wire             mc_en;
  wire             apb_setup;
  wire             apb_write;
  wire             mapped;
  wire             busy;

  function addr_is;
    input [7:0] a;
    input [7:0] off;
    begin
      addr_is = (a == off);
    end
  endfunction

  assign t_pin = {test_input_one, test_input_zero};

  // Pins are asynchronous; filtered level changes only once two stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_test_sync
      // Reset level high so no false low is seen right after reset
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          t_sync_ff[gi]  <= `RST_TEST_SYNC;
          t_level_ff[gi] <= 1'b1;
        end else begin
          t_sync_ff[gi] <= {t_sync_ff[gi][1:0], t_pin[gi]};
          if (t_sync_ff[gi][1] == t_sync_ff[gi][2])
            t_level_ff[gi] <= t_sync_ff[gi][2];
        end
      end
    end
  endgenerate

  // Machine cycle divider, restarted while idle so the first cycle is full
  assign mc_en = (div_ff == MC_LAST);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      div_ff <= {DIV_W{1'b0}};
    else if (state_ff == ST_IDLE || mc_en)
      div_ff <= {DIV_W{1'b0}};
    else
      div_ff <= div_ff + {{(DIV_W-1){1'b0}}, 1'b1};
  end

  jump_condition_eval u_eval (
    .opcode          (op_ff),
    .carry           (carry_ff),
    .user_flag_zero  (user_flag_zero_ff),
    .user_flag_one   (user_flag_one_ff),
    .test_input_zero (t_level_ff[0]),
    .test_input_one  (t_level_ff[1]),
    .acc             (acc_ff),
    .is_jump         (is_jump),
    .take            (take)
  );

  // Probe decodes the fetched byte before it is latched
  wire             op_is_jump;
  wire [7:0]       op_probe;
  assign op_probe = pm_data;

  jump_condition_eval u_probe (
    .opcode          (op_probe),
    .carry           (carry_ff),
    .user_flag_zero  (user_flag_zero_ff),
    .user_flag_one   (user_flag_one_ff),
    .test_input_zero (t_level_ff[0]),
    .test_input_one  (t_level_ff[1]),
    .acc             (acc_ff),
    .is_jump         (op_is_jump),
    .take            ()
  );

  // Jump outcomes; page bits come from the opcode address, not PC plus one
  assign pc_target = {pc_ff[PC_W-1:`PC_PAGE_MSB+1], pm_data};
  assign pc_fall   = pc_ff + `PC_STEP_TWO;

  // Sequencer: one machine cycle per program byte
  always @* begin
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    nxt_addr  = pm_addr;
    nxt_op    = op_ff;
    nxt_taken = taken_ff;
    case (state_ff)
      ST_IDLE: begin
        if (run_ff) begin
          nxt_state = ST_OP;
          nxt_addr  = pc_ff;
        end
      end
      ST_OP: begin
        if (mc_en) begin
          nxt_op = pm_data;
          if (op_is_jump) begin
            // Jump opcodes need the target byte as well
            nxt_state = ST_ARG;
            nxt_addr  = pc_ff + `PC_STEP_ONE;
          end else begin
            // Other opcodes belong to other units; step over them
            nxt_pc    = pc_ff + `PC_STEP_ONE;
            nxt_addr  = nxt_pc;
            nxt_state = run_ff ? ST_OP : ST_IDLE;
          end
        end
      end
      ST_ARG: begin
        if (mc_en) begin
          nxt_taken = take & is_jump;
          if (take & is_jump)
            nxt_pc = pc_target;
          else
            nxt_pc = pc_fall;
          nxt_addr  = nxt_pc;
          nxt_state = run_ff ? ST_OP : ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  assign busy  = (state_ff != ST_IDLE);
  assign pm_rd = busy;

  // APB slave, zero wait states: every register is a flop or a constant
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;
  assign pready    = 1'b1;
  assign mapped    = addr_is(paddr, `REG_CTRL)   | addr_is(paddr, `REG_FLAGS) |
                     addr_is(paddr, `REG_ACC)    | addr_is(paddr, `REG_PC)    |
                     addr_is(paddr, `REG_STATUS) | addr_is(paddr, `REG_TAKEN_COUNT);
  assign pslverr   = psel & penable & ~mapped;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      pm_addr  <= `RST_PC;
      op_ff    <= `RST_BYTE;
      taken_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pm_addr  <= nxt_addr;
      op_ff    <= nxt_op;
      taken_ff <= nxt_taken;
    end
  end

  // PC load only while stopped so a running fetch is never torn
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pc_ff <= `RST_PC;
    else if (apb_write && addr_is(paddr, `REG_PC) && !busy)
      pc_ff <= pwdata[PC_W-1:0];
    else
      pc_ff <= nxt_pc;
  end

  // Sixteen bits wrap silently; software reads differences, not totals
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      taken_count_ff <= `RST_COUNT;
    else if (state_ff == ST_ARG && mc_en && take && is_jump)
      taken_count_ff <= taken_count_ff + 16'h0001;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff            <= 1'b0;
      carry_ff          <= 1'b0;
      user_flag_zero_ff <= 1'b0;
      user_flag_one_ff  <= 1'b0;
      acc_ff            <= `RST_BYTE;
    end else if (apb_write) begin
      // Writes land only in the access phase
      if (addr_is(paddr, `REG_CTRL))
        run_ff <= pwdata[`CTRL_RUN_BIT];
      if (addr_is(paddr, `REG_FLAGS)) begin
        carry_ff          <= pwdata[`FLAGS_CARRY_BIT];
        user_flag_zero_ff <= pwdata[`FLAGS_USER_ZERO_BIT];
        user_flag_one_ff  <= pwdata[`FLAGS_USER_ONE_BIT];
      end
      if (addr_is(paddr, `REG_ACC))
        acc_ff <= pwdata[7:0];
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    nxt_rdata = `RST_WORD;
    case (1'b1)
      addr_is(paddr, `REG_CTRL):
        nxt_rdata[`CTRL_RUN_BIT] = run_ff;
      addr_is(paddr, `REG_FLAGS): begin
        nxt_rdata[`FLAGS_CARRY_BIT]     = carry_ff;
        nxt_rdata[`FLAGS_USER_ZERO_BIT] = user_flag_zero_ff;
        nxt_rdata[`FLAGS_USER_ONE_BIT]  = user_flag_one_ff;
      end
      addr_is(paddr, `REG_ACC):
        nxt_rdata[7:0] = acc_ff;
      addr_is(paddr, `REG_PC):
        nxt_rdata[PC_W-1:0] = pc_ff;
      addr_is(paddr, `REG_STATUS): begin
        nxt_rdata[`STATUS_BUSY_BIT]      = busy;
        nxt_rdata[`STATUS_TAKEN_BIT]     = taken_ff;
        nxt_rdata[`STATUS_TEST_ZERO_BIT] = t_level_ff[0];
        nxt_rdata[`STATUS_TEST_ONE_BIT]  = t_level_ff[1];
        nxt_rdata[`STATUS_OPCODE_MSB:`STATUS_OPCODE_LSB] = op_ff;
      end
      addr_is(paddr, `REG_TAKEN_COUNT):
        nxt_rdata[15:0] = taken_count_ff;
      default:
        nxt_rdata = `RST_WORD;
    endcase
  end

  // Latched in the setup cycle so data hold through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= `RST_WORD;
    else if (apb_setup)
      prdata <= nxt_rdata;
  end

endmodule // cond_jump_decode

/* File: tb/cond_jump_properties.sv */
`timescale 1ns/100ps
`include "cond_jump_defs.vh"
module cond_jump_properties #(parameter PC_W = 12, parameter MC_DIV = 8) (
  // Clock and reset
  input wire            pclk,
  input wire            presetn,
  // APB
  input wire [7:0]      paddr,
  input wire            psel,
  input wire            penable,
  input wire            pwrite,
  input wire [31:0]     pwdata,
  // Fetch and pins
  input wire [PC_W-1:0] pm_addr,
  input wire            pm_rd,
  input wire [7:0]      pm_data,
  input wire            test_input_zero,
  input wire            test_input_one
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [PC_W-1:0] last_ff, op_addr_ff;
  reg [7:0]      byte_ff, op_ff, acc_ff, cnt_ff;
  reg [2:0]      flags_ff;
  reg            rd_ff, op_vld_ff, cnt_vld_ff;
  // Last step may drop pm_rd at the same edge, so qualify with the old level
  wire step = rd_ff && pm_addr != last_ff;
  wire pair = step && op_vld_ff && last_ff == op_addr_ff + 1'b1;
  wire jmp = op_ff[4:0] == 5'h12 || (op_ff[3:0] == 4'h6 && op_ff[7:4] inside {4'hF, 4'hB,
    4'h7, 4'h2, 4'h4});
  wire [PC_W-1:0] tk = {op_addr_ff[PC_W-1:8], byte_ff};
  wire [PC_W-1:0] nt = op_addr_ff + 2'h2;
  wire            wr = psel && penable && pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rd_ff, op_vld_ff, cnt_vld_ff} <= 3'h0;
      {flags_ff, acc_ff} <= 11'h000;
    end else begin
      rd_ff <= pm_rd;
      last_ff <= pm_addr;
      byte_ff <= pm_data;
      cnt_ff <= step ? 8'h00 : cnt_ff + 8'h01;
      cnt_vld_ff <= pm_rd && (cnt_vld_ff || step);
      if (step) begin
        op_vld_ff <= !(pair && jmp);
        op_addr_ff <= last_ff;
        op_ff <= byte_ff;
      end else if (!rd_ff) begin
        op_vld_ff <= 1'b0;
      end
      if (wr && paddr == `REG_FLAGS) flags_ff <= pwdata[2:0];
      if (wr && paddr == `REG_ACC) acc_ff <= pwdata[7:0];
    end
  end
  a_carry_jump: assert property (
    pair && op_ff == `OP_JUMP_ON_CARRY |-> pm_addr == (flags_ff[0] ? tk : nt))
    else $error("carry jump address wrong");
  a_flag0_jump: assert property (
    pair && op_ff == `OP_JUMP_ON_USER_FLAG_ZERO |-> pm_addr == (flags_ff[1] ? tk : nt))
    else $error("flag zero jump address wrong");
  a_flag1_jump: assert property (
    pair && op_ff == `OP_JUMP_ON_USER_FLAG_ONE |-> pm_addr == (flags_ff[2] ? tk : nt))
    else $error("flag one jump address wrong");
  a_test0_jump: assert property (
    pair && op_ff == `OP_JUMP_TEST_ZERO_LOW |-> pm_addr == (test_input_zero ? nt : tk))
    else $error("test zero jump address wrong");
  a_test1_jump: assert property (
    pair && op_ff == `OP_JUMP_TEST_ONE_LOW |-> pm_addr == (test_input_one ? nt : tk))
    else $error("test one jump address wrong");
  a_acc_bit_jump: assert property (
    pair && op_ff[4:0] == 5'h12 |-> pm_addr == (acc_ff[op_ff[7:5]] ? tk : nt))
    else $error("accumulator bit jump address wrong");
  a_page_kept: assert property (
    pair && jmp && pm_addr != nt |-> pm_addr[PC_W-1:8] == op_addr_ff[PC_W-1:8])
    else $error("taken jump left its page");
  a_mc_length: assert property (
    step && cnt_vld_ff |-> cnt_ff == MC_DIV - 1)
    else $error("machine cycle length wrong");
endmodule // cond_jump_properties
bind cond_jump_decode cond_jump_properties #(.PC_W(PC_W), .MC_DIV(MC_DIV)) chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data),
  .test_input_zero(test_input_zero), .test_input_one(test_input_one));

/* File: tb/prog_mem.sv */
`timescale 1ns/100ps
module prog_mem (
  // Clock
  input  wire        pclk,
  // Fetch port
  input  wire [11:0] pm_addr,
  input  wire        pm_rd,
  output reg  [7:0]  pm_data
);
  reg [7:0]  mem [0:4095];
  reg [11:0] addr_ff;
  integer    lat;
  integer    wait_cnt;
  initial begin
    pm_data = 8'h00;
    lat = 0;
    wait_cnt = 0;
  end
  // Stale byte toggles so a held old value cannot pass as valid
  always @(posedge pclk) begin
    addr_ff <= pm_addr;
    if (!pm_rd || pm_addr != addr_ff) wait_cnt <= lat;
    else if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
    if (pm_rd && pm_addr == addr_ff && wait_cnt == 0) pm_data <= mem[pm_addr];
    else pm_data <= ~pm_data;
  end
endmodule // prog_mem

/* File: tb/cond_jump_decode_tb.sv */
`timescale 1ns/100ps
`include "cond_jump_defs.vh"
module cond_jump_decode_tb;
  localparam [55:0] OPS = {`OP_JUMP_ON_CARRY, `OP_JUMP_ON_USER_FLAG_ZERO,
    `OP_JUMP_ON_USER_FLAG_ONE, `OP_JUMP_TEST_ZERO_LOW, `OP_JUMP_TEST_ONE_LOW, 8'h12, 8'hD2};
  reg         pclk, presetn, psel, penable, pwrite, test_input_zero, test_input_one, e;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, q;
  wire [31:0] prdata;
  wire        pready, pslverr, pm_rd;
  wire [11:0] pm_addr;
  wire [7:0]  pm_data;
  integer     n_mismatch, cmp_count, taken_n;
  cond_jump_decode #(.MC_DIV(8)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data),
    .test_input_zero(test_input_zero), .test_input_one(test_input_one));
  prog_mem pmem (.pclk(pclk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task end_of_test;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task apb(input [7:0] a, input w, input [31:0] d);
    integer i;
    begin
      @(posedge pclk);
      {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && i < 20) begin
        @(posedge pclk);
        i = i + 1;
      end
      if (i >= 20) n_mismatch = n_mismatch + 1;
      if (i >= 20) end_of_test;
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  task t_reset;
    integer k;
    begin
      for (k = 0; k < 7; k = k + 1) begin
        apb({k[5:0], 2'b00}, 1'b0, 32'h0);
        check(q, k == 4 ? 32'h0000000C : 32'h0);
        check({31'h0, e}, {31'h0, k == 6});
        check({31'h0, pready}, 32'h1);
      end
    end
  endtask
  // Opcode sits at the page end, so the fall-through address crosses the page
  task t_jumps;
    integer i, k, n;
    reg [7:0] op, ac, tgt;
    reg [2:0] fl;
    reg       tk;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        for (k = 0; k < 4; k = k + 1) begin
          op = OPS[(6 - i) * 8 +: 8];
          fl = 3'h1 << k;
          ac = k[0] ? 8'hA5 : 8'h5A;
          tgt = 8'h30 + k[7:0];
          tk = i == 0 ? fl[0] : i == 1 ? fl[1] : i == 2 ? fl[2] : i == 3 ? !k[0] : i == 4 ?
            !k[1] : ac[op[7:5]];
          pmem.mem[12'h3FE] = op;
          pmem.mem[12'h3FF] = tgt;
          pmem.lat = k[0] ? 4 : 0;
          test_input_zero <= k[0];
          test_input_one <= k[1];
          apb(`REG_FLAGS, 1'b1, {29'h0, fl});
          apb(`REG_ACC, 1'b1, {24'h0, ac});
          apb(`REG_PC, 1'b1, 32'h3FE);
          apb(`REG_CTRL, 1'b1, 32'h1);
          apb(`REG_CTRL, 1'b1, 32'h0);
          q = 32'h1;
          for (n = 0; n < 40 && q[0] !== 1'b0; n = n + 1) apb(`REG_STATUS, 1'b0, 32'h0);
          check({31'h0, q[0]}, 32'h0);
          if (q[0] !== 1'b0) end_of_test;
          check(q, {16'h0, op, 4'h0, k[1], k[0], tk, 1'b0});
          apb(`REG_PC, 1'b0, 32'h0);
          check(q, tk ? {24'h3, tgt} : 32'h400);
          taken_n = taken_n + tk;
          apb(`REG_TAKEN_COUNT, 1'b0, 32'h0);
          check(q, taken_n);
        end
      end
    end
  endtask
  initial begin
    {n_mismatch, cmp_count, taken_n} = 96'h0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    {test_input_zero, test_input_one} = 2'b11;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_jumps;
    end_of_test;
  end
endmodule // cond_jump_decode_tb
